// >>> logic/fault_and_interrupt_pending_mask.sv
// Pending interrupt, fault and mask registers with service request output.
`timescale 1ns/100ps
`include "fault_irq_params.svh"

module fault_and_interrupt_pending_mask
   import fault_irq_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire io_cmd_t ioCmd,
   input wire logic [1:0] readSel,
   output logic [15:0] readData,
   input wire logic [15:0] irqSources,
   input wire fault_src_t faultSrc,
   input wire logic [1:0] spareFaults,
   input wire logic xmitFaultPin,
   input wire logic globalIrqEnable,
   input wire logic ackRedirect,
   output redirect_t redirect,
   output logic machineError
);
   logic [15:0] pending_ff;
   logic [15:0] fault_ff;
   logic [15:0] mask_ff;
   logic [15:0] readData_ff;
   logic [15:0] nxt_pending;
   logic [15:0] nxt_fault;
   logic [15:0] nxt_mask;
   logic xmitFaultSync;
   logic [15:0] faultSet;
   logic [15:0] pendingSet;
   logic [15:0] serviceable;
   logic [3:0] topLevel;
   logic [15:0] ackMask;

   pin_sync xmitSync (
      .clk(clk),
      .rstn(rstn),
      .pinIn(xmitFaultPin),
      .pinOut(xmitFaultSync)
   );

   wire pendSel = ioCmd.sel == `SEL_PENDING;
   wire faultSel = ioCmd.sel == `SEL_FAULT;
   wire maskSel = ioCmd.sel == `SEL_MASK;
   wire opWrite = ioCmd.op == OP_WRITE;
   wire opSet = ioCmd.op == OP_SET;
   wire opClear = ioCmd.op == OP_CLEAR;

   // One strobe per register and operation, so each next-state block
   // reads a single named condition.
   wire pendWrite = pendSel && opWrite;
   wire pendSetOp = pendSel && opSet;
   wire pendClearOp = pendSel && opClear;
   wire faultWrite = faultSel && opWrite;
   wire faultSetOp = faultSel && opSet;
   wire faultClearOp = faultSel && opClear;
   wire maskWrite = maskSel && opWrite;
   wire maskSetOp = maskSel && opSet;
   wire maskClearOp = maskSel && opClear;

   // Software reaches only the fault bits that are not hardware-only flags.
   wire [15:0] faultUserData = ioCmd.data & ~`FAULT_NOUSER;
   wire [15:0] faultHeld = fault_ff & `FAULT_NOUSER;

   // Hardware fault events in their bit positions.
   always_comb begin
      faultSet = 16'h0000;
      faultSet[`FB_CPUPROT] = faultSrc.cpuProtect;
      faultSet[`FB_DMAPROT] = faultSrc.dmaProtect;
      faultSet[`FB_MEMPAR] = faultSrc.memParity;
      faultSet[`FB_PIOPAR] = faultSrc.pioParity;
      faultSet[`FB_DMAPAR] = faultSrc.dmaParity;
      faultSet[`FB_ILLCMD] = faultSrc.illegalCmd;
      faultSet[`FB_XMIT] = xmitFaultSync;
      faultSet[`FB_SYS] = faultSrc.systemFault;
      faultSet[`FB_ILLADDR] = faultSrc.illegalAddr;
      faultSet[`FB_ILLINS] = faultSrc.illegalInstr;
      faultSet[`FB_PRIV] = faultSrc.privInstr;
      faultSet[`FB_ASTATE] = faultSrc.addrState;
      faultSet[`FB_BIT] = faultSrc.builtinTest;
      faultSet[1:0] = spareFaults;
   end

   // Software edits apply first; hardware sets win over a same-cycle clear.
   always_comb begin
      nxt_fault = fault_ff;
      if (faultWrite) begin
         nxt_fault = faultHeld | faultUserData;
      end else if (faultSetOp) begin
         nxt_fault = fault_ff | faultUserData;
      end else if (faultClearOp) begin
         nxt_fault = fault_ff & ~faultUserData;
      end
      nxt_fault = (nxt_fault | faultSet) & `FAULT_USED;
   end

   assign machineError = |fault_ff;
   always_comb begin
      pendingSet = irqSources;
      pendingSet[`BIT_MCHERR] = machineError;
   end

   // The acknowledged level is retired when the core takes the redirect.
   always_comb begin
      ackMask = 16'h0000;
      if (ackRedirect && redirect.req) begin
         ackMask[topLevel] = 1'b1;
      end
   end

   always_comb begin
      nxt_pending = pending_ff & ~ackMask;
      if (pendWrite) begin
         nxt_pending = ioCmd.data;
      end else if (pendSetOp) begin
         nxt_pending = pending_ff | ioCmd.data;
      end else if (pendClearOp) begin
         nxt_pending = pending_ff & ~ioCmd.data;
      end
      nxt_pending = nxt_pending | pendingSet;
   end

   always_comb begin
      nxt_mask = mask_ff;
      if (maskWrite) begin
         nxt_mask = ioCmd.data;
      end else if (maskSetOp) begin
         nxt_mask = mask_ff | ioCmd.data;
      end else if (maskClearOp) begin
         nxt_mask = mask_ff & ~ioCmd.data;
      end
   end

   // Unmaskable levels bypass the mask; masked ones remain pending.
   wire [15:0] unmaskable = `NOMASK | (16'h0001 << `BIT_MCHERR);
   wire [15:0] maskEffective = mask_ff | unmaskable;
   assign serviceable = pending_ff & maskEffective;

   // Fixed priority: the highest serviceable bit number is taken first.
   assign topLevel = serviceable[15] ? 4'hF
      : serviceable[14] ? 4'hE
      : serviceable[13] ? 4'hD
      : serviceable[12] ? 4'hC
      : serviceable[11] ? 4'hB
      : serviceable[10] ? 4'hA
      : serviceable[9] ? 4'h9
      : serviceable[8] ? 4'h8
      : serviceable[7] ? 4'h7
      : serviceable[6] ? 4'h6
      : serviceable[5] ? 4'h5
      : serviceable[4] ? 4'h4
      : serviceable[3] ? 4'h3
      : serviceable[2] ? 4'h2
      : serviceable[1] ? 4'h1
      : 4'h0;

   assign redirect.req = globalIrqEnable && (|serviceable);
   assign redirect.level = topLevel;

   wire [15:0] readMux = (readSel == `SEL_PENDING) ? pending_ff
      : (readSel == `SEL_FAULT) ? fault_ff
      : (readSel == `SEL_MASK) ? mask_ff : 16'h0000;

   // Pending register: software edits, hardware sets and retired levels.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pending_ff <= `PEND_RESET;
      end else begin
         pending_ff <= nxt_pending;
      end
   end

   // Fault register: every flag clears at reset.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fault_ff <= `FAULT_RESET;
      end else begin
         fault_ff <= nxt_fault;
      end
   end

   // Mask register: bits are stored even where they have no effect.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mask_ff <= `MASK_RESET;
      end else begin
         mask_ff <= nxt_mask;
      end
   end

   // Read data is registered so the port never shows a glitching mux.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         readData_ff <= 16'h0000;
      end else begin
         readData_ff <= readMux;
      end
   end

   assign readData = readData_ff;
endmodule

// >>> logic/fault_irq_params.svh
// Register selects, field positions and reset values of the interrupt block.
`ifndef FAULT_IRQ_PARAMS_SVH
`define FAULT_IRQ_PARAMS_SVH
`define SEL_PENDING 2'h0
`define SEL_FAULT 2'h1
`define SEL_MASK 2'h2
`define PEND_RESET 16'h0000
`define FAULT_RESET 16'h0000
`define MASK_RESET 16'h0000
`define FAULT_USED 16'hFFF7
`define FAULT_NOUSER 16'h1A00
`define BIT_PWRDN 4'hF
`define BIT_MCHERR 4'hE
`define BIT_EXCALL 4'hA
`define NOMASK 16'h8400
`define FB_CPUPROT 4'hF
`define FB_DMAPROT 4'hE
`define FB_MEMPAR 4'hD
`define FB_PIOPAR 4'hC
`define FB_DMAPAR 4'hB
`define FB_ILLCMD 4'hA
`define FB_XMIT 4'h9
`define FB_SYS 4'h8
`define FB_ILLADDR 4'h7
`define FB_ILLINS 4'h6
`define FB_PRIV 4'h5
`define FB_ASTATE 4'h4
`define FB_BIT 4'h2
`endif

// >>> logic/fault_irq_pkg.sv
// Types shared by the interrupt and fault collection block.
package fault_irq_pkg;
   typedef enum logic [1:0] {
      OP_NONE,
      OP_WRITE,
      OP_SET,
      OP_CLEAR
   } io_op_t;
   typedef struct packed {
      io_op_t op;
      logic [1:0] sel;
      logic [15:0] data;
   } io_cmd_t;
   typedef struct packed {
      logic cpuProtect;
      logic dmaProtect;
      logic memParity;
      logic pioParity;
      logic dmaParity;
      logic illegalCmd;
      logic systemFault;
      logic illegalAddr;
      logic illegalInstr;
      logic privInstr;
      logic addrState;
      logic builtinTest;
   } fault_src_t;
   typedef struct packed {
      logic req;
      logic [3:0] level;
   } redirect_t;
endpackage

// >>> logic/pin_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/100ps
module pin_sync (
   input wire logic clk,
   input wire logic rstn,
   input wire logic pinIn,
   output logic pinOut
);
   logic [2:0] stage_ff;
   logic out_ff;
   wire agree = stage_ff[1] == stage_ff[2];
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stage_ff <= 3'h0;
         out_ff <= 1'b0;
      end else begin
         stage_ff <= {stage_ff[1:0], pinIn};
         if (agree) begin
            out_ff <= stage_ff[2];
         end
      end
   end
   assign pinOut = out_ff;
endmodule

// >>> sim/fault_irq_properties.sv
// Concurrent checks on the ports of the interrupt and fault block.
`timescale 1ns/100ps
module fault_irq_properties
   import fault_irq_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire io_cmd_t ioCmd,
   input wire logic [1:0] readSel,
   input wire logic [15:0] readData,
   input wire logic [15:0] irqSources,
   input wire fault_src_t faultSrc,
   input wire logic [1:0] spareFaults,
   input wire logic xmitFaultPin,
   input wire logic globalIrqEnable,
   input wire logic ackRedirect,
   input wire redirect_t redirect,
   input wire logic machineError
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence maskLoad;
      ioCmd.op == OP_WRITE && ioCmd.sel == 2'h2 ##2 readSel == 2'h2;
   endsequence
   a_mask_readback:
   assert property (maskLoad |=> readData == $past(ioCmd.data, 3))
      else $error("mask readback wrong");
   a_bit3_zero:
   assert property (readSel == 2'h1 |=> !readData[3])
      else $error("fault bit 3 set");
   a_sel3_zero:
   assert property (readSel == 2'h3 |=> readData == 16'h0000)
      else $error("unused select not zero");
   a_enable_gates:
   assert property (!globalIrqEnable |-> !redirect.req)
      else $error("request while disabled");
   a_mcherr_unmasked:
   assert property (machineError && globalIrqEnable |-> ##[0:2] redirect.req)
      else $error("machine error not requested");
   a_cpu_protect:
   assert property (faultSrc.cpuProtect |=> machineError)
      else $error("protect fault lost");
   a_xmit_fault:
   assert property (xmitFaultPin [*8] |-> machineError)
      else $error("transmission fault lost");
   a_pwrdn_first:
   assert property (irqSources[15] && globalIrqEnable
      |=> redirect.req && redirect.level == 4'hF)
      else $error("power-down not served first");
endmodule
bind fault_and_interrupt_pending_mask fault_irq_properties i_props (.clk,
   .rstn, .ioCmd, .readSel, .readData, .irqSources, .faultSrc, .spareFaults,
   .xmitFaultPin, .globalIrqEnable, .ackRedirect, .redirect, .machineError);

// >>> sim/core_ack_model.sv
// Core model that takes a redirect request after a set number of cycles.
`timescale 1ns/100ps
module core_ack_model #(parameter int DLY = 2) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic req,
   output logic ack
);
   int cnt;
   always @(negedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt = 0;
         ack = 1'b0;
      end else begin
         ack = req && cnt == DLY;
         cnt = (req && cnt < DLY) ? cnt + 1 : 0;
      end
   end
endmodule

// >>> sim/fault_and_interrupt_pending_mask_tb_top.sv
// Directed testbench for the interrupt and fault collection block.
`timescale 1ns/100ps
`include "fault_irq_params.svh"
module fault_and_interrupt_pending_mask_tb_top;
   import fault_irq_pkg::*;
   logic clk, rstn, xmitFaultPin, globalIrqEnable, ackRedirect, machineError;
   io_cmd_t ioCmd;
   logic [1:0] readSel, spareFaults;
   logic [15:0] readData, irqSources, exp;
   fault_src_t faultSrc;
   redirect_t redirect;
   int err_count, checked;
   localparam logic [3:0] POS [12] = '{4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
      4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
   fault_and_interrupt_pending_mask i_dut (.clk, .rstn, .ioCmd, .readSel,
      .readData, .irqSources, .faultSrc, .spareFaults, .xmitFaultPin,
      .globalIrqEnable, .ackRedirect, .redirect, .machineError);
   core_ack_model i_core (.clk, .rstn, .req(redirect.req), .ack(ackRedirect));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task step(int n);
      repeat (n) @(negedge clk);
   endtask
   task chk(logic [15:0] got, logic [15:0] want);
      checked++;
      if (got !== want) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, want);
      end
   endtask
   task cmd(io_op_t op, logic [1:0] sel, logic [15:0] d);
      ioCmd = '{op, sel, d};
      step(1);
      ioCmd.op = OP_NONE;
      step(1);
   endtask
   task rd(logic [1:0] sel, logic [15:0] want);
      readSel = sel;
      step(1);
      chk(readData, want);
   endtask
   task end_sim;
      if (err_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #50000;
      err_count++;
      end_sim;
   end
   initial begin
      rstn = 1'b0;
      ioCmd = '{OP_NONE, 2'h0, 16'h0000};
      readSel = 2'h0;
      irqSources = 16'h0000;
      faultSrc = '0;
      spareFaults = 2'h0;
      xmitFaultPin = 1'b0;
      globalIrqEnable = 1'b0;
      step(5);
      rstn = 1'b1;
      step(1);
      for (int s = 0; s < 4; s++) rd(s[1:0], 16'h0000);
      cmd(OP_SET, `SEL_PENDING, 16'h0005);
      rd(`SEL_PENDING, 16'h0005);
      cmd(OP_CLEAR, `SEL_PENDING, 16'h0001);
      irqSources = 16'h0008;
      step(1);
      irqSources = 16'h0000;
      rd(`SEL_PENDING, 16'h000C);
      cmd(OP_WRITE, `SEL_PENDING, 16'h0000);
      cmd(OP_WRITE, `SEL_MASK, 16'hFFFF);
      rd(`SEL_MASK, 16'hFFFF);
      cmd(OP_WRITE, `SEL_MASK, 16'h0000);
      cmd(OP_WRITE, `SEL_FAULT, 16'hFFFF);
      rd(`SEL_FAULT, 16'hE5F7);
      chk(machineError, 16'h0001);
      cmd(OP_CLEAR, `SEL_FAULT, 16'hFFFF);
      rd(`SEL_FAULT, 16'h0000);
      rd(`SEL_PENDING, 16'h4000);
      cmd(OP_WRITE, `SEL_PENDING, 16'h0000);
      globalIrqEnable = 1'b1;
      irqSources = 16'h8008;
      step(1);
      irqSources = 16'h0000;
      chk(redirect, 16'h001F);
      step(6);
      chk(redirect.req, 16'h0000);
      rd(`SEL_PENDING, 16'h0008);
      cmd(OP_WRITE, `SEL_MASK, 16'h0408);
      chk(redirect, 16'h0013);
      step(6);
      rd(`SEL_PENDING, 16'h0000);
      cmd(OP_SET, `SEL_MASK, 16'h0003);
      rd(`SEL_MASK, 16'h040B);
      cmd(OP_CLEAR, `SEL_MASK, 16'h0408);
      rd(`SEL_MASK, 16'h0003);
      irqSources = 16'h0400;
      step(1);
      irqSources = 16'h0000;
      chk(redirect, 16'h001A);
      step(6);
      rd(`SEL_PENDING, 16'h0000);
      cmd(OP_WRITE, 2'h3, 16'hFFFF);
      rd(`SEL_MASK, 16'h0003);
      rd(`SEL_PENDING, 16'h0000);
      cmd(OP_SET, `SEL_FAULT, 16'h1A01);
      rd(`SEL_FAULT, 16'h0001);
      cmd(OP_WRITE, `SEL_FAULT, 16'h0000);
      step(6);
      exp = 16'h0000;
      for (int i = 0; i < 12; i++) begin
         faultSrc[i] = 1'b1;
         step(1);
         faultSrc = '0;
         exp = (exp & 16'h1A00) | (16'h0001 << POS[i]);
         rd(`SEL_FAULT, exp);
         cmd(OP_WRITE, `SEL_FAULT, 16'h0000);
      end
      spareFaults = 2'h3;
      step(1);
      spareFaults = 2'h0;
      rd(`SEL_FAULT, 16'h1803);
      cmd(OP_WRITE, `SEL_FAULT, 16'h0000);
      xmitFaultPin = 1'b1;
      step(8);
      xmitFaultPin = 1'b0;
      step(4);
      rd(`SEL_FAULT, 16'h1A00);
      end_sim;
   end
endmodule
